// ---- design/awce_defs.vh ----
// Constants of the write command engine: task-file offsets,
// command codes, status and error bits, reset values, timing.
// Assumes inclusion by bare name from the engine source.
`ifndef AWCE_DEFS_VH
`define AWCE_DEFS_VH
// Task-file offsets on the three address pins
`define AWCE_OFS_DATA 3'h0
`define AWCE_OFS_FEAT 3'h1
`define AWCE_OFS_LEN 3'h2
`define AWCE_OFS_SNUM 3'h3
`define AWCE_OFS_MID 3'h4
`define AWCE_OFS_HIGH 3'h5
`define AWCE_OFS_DH 3'h6
`define AWCE_OFS_CMD 3'h7
// Command codes
`define AWCE_CMD_WRS0 8'h30
`define AWCE_CMD_WRS1 8'h31
`define AWCE_CMD_WLONG0 8'h32
`define AWCE_CMD_WLONG1 8'h33
`define AWCE_CMD_WRNE 8'h38
`define AWCE_CMD_WVER 8'h3c
`define AWCE_CMD_WMUL 8'hc5
`define AWCE_CMD_SETMUL 8'hc6
`define AWCE_CMD_WMULNE 8'hcd
`define AWCE_CMD_WBUF 8'he8
// Status bit positions
`define AWCE_ST_BUSY 7
`define AWCE_ST_RDY 6
`define AWCE_ST_WF 5
`define AWCE_ST_SEEK 4
`define AWCE_ST_DRQ 3
`define AWCE_ST_ERR 0
// Error register value for an aborted command
`define AWCE_ER_ABRT 8'h04
// Media operation codes
`define AWCE_OP_WR 2'h0
`define AWCE_OP_WRNE 2'h1
`define AWCE_OP_WVER 2'h2
`define AWCE_OP_BUF 2'h3
// Reset values of the task file
`define AWCE_RST_LEN 8'h01
`define AWCE_RST_SNUM 8'h01
`define AWCE_RST_ZERO 8'h00
`define AWCE_RST_DH 8'ha0
// Status after reset: ready and seek complete, nothing pending
`define AWCE_RST_STAT 8'h50
// Pin sampler idle word: chip select, write and read strobes high
`define AWCE_PIN_IDLE 22'h230000
// Words per sector less one, long-write words less one, sectors for a zero count
`define AWCE_SEC_LAST 9'h0ff
`define AWCE_LONG_LAST 9'h101
`define AWCE_FULL_SECS 9'h100
// Timing: busy is held this long after command acceptance, before DRQ
`define AWCE_T_BUSY_NS 400
`define AWCE_CLK_NS 100
`define AWCE_BUSY_CYC ((`AWCE_T_BUSY_NS / `AWCE_CLK_NS) < 1 ? 1 : \
	(`AWCE_T_BUSY_NS / `AWCE_CLK_NS))
`endif

// ---- design/awce_engine.v ----
// Write command engine of a flash disk: task file, write command
// sequencing, data FIFO towards the flash media.
// Assumes IDE strobes are asynchronous and slow against a 10 MHz
// clock, and that the media answers each sector commit in order.
`timescale 1ns/10ps

// Data FIFO in flip-flops; flags are registered
module awce_fifo #(
	parameter W  = 16,
	parameter D  = 8,
	parameter AW = 3
) (
	input  wire         clock_i,
	input  wire         rst_i,
	input  wire         in_valid_i,
	input  wire [W-1:0] in_data_i,
	output reg          in_ready_o,
	output reg          out_valid_o,
	output wire [W-1:0] out_data_o,
	input  wire         out_ready_i
);
	localparam [AW:0] DEPTH = D[AW:0]; // Depth cut to the fill-level width
	reg [W-1:0]  mem [0:D-1];   // Storage
	reg [AW-1:0] wp;            // Write index
	reg [AW-1:0] rp;            // Read index
	reg [AW:0]   cnt;           // Fill level
	reg [AW:0]   next_cnt;      // Fill level after this edge
	wire         push;          // Word accepted
	wire         pop;           // Word drained

	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;
	assign out_data_o = mem[rp];

	// Next fill level
	always @* begin
		next_cnt = cnt;
		if (push & ~pop)
			next_cnt = cnt + 1'b1;
		else if (pop & ~push)
			next_cnt = cnt - 1'b1;
	end

	// Pointers and flags
	always @(posedge clock_i) begin
		if (rst_i) begin
			wp <= {AW{1'b0}};
			rp <= {AW{1'b0}};
			cnt <= {(AW+1){1'b0}};
			in_ready_o <= 1'b1;
			out_valid_o <= 1'b0;
		end else begin
			if (push) begin
				mem[wp] <= in_data_i;
				wp <= (wp == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp + 1'b1;
			end
			if (pop)
				rp <= (rp == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp + 1'b1;
			cnt <= next_cnt;
			in_ready_o <= (next_cnt != DEPTH);
			out_valid_o <= (next_cnt != {(AW+1){1'b0}});
		end
	end
endmodule

// Top of the engine
module awce_engine #(
	parameter MAX_BLK = 16,     // Largest block size accepted
	parameter FDEPTH  = 8       // FIFO depth in words
) (
	input  wire        clock_i,
	input  wire        rst_i,
	input  wire        ide_cs_n_i,
	input  wire [2:0]  ide_addr_i,
	input  wire        ide_wr_n_i,
	input  wire        ide_rd_n_i,
	input  wire [15:0] ide_d_i,
	output reg  [15:0] ide_d_o,
	output reg         ide_d_oe_n_o,
	output reg         ide_intrq_o,
	output wire        media_valid_o,
	output wire [15:0] media_data_o,
	input  wire        media_ready_i,
	output reg         media_commit_o,
	output reg  [27:0] media_lba_o,
	output reg  [1:0]  media_op_o,
	input  wire        media_done_i,
	input  wire        media_fail_i
);
`include "awce_defs.vh"
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_SETUP = 3'h1;
	localparam [2:0] ST_XFER = 3'h2;
	localparam [2:0] ST_DRAIN = 3'h3;
	localparam integer BUSY_INT = `AWCE_BUSY_CYC;
	localparam [3:0] BUSY_CYC = BUSY_INT[3:0];   // Busy hold in clocks
	localparam [8:0] MAXB = MAX_BLK[8:0];         // Largest block, counter width

	// Pin samplers; only stage two feeds logic
	reg [21:0] pin1;            // First sampler stage
	reg [21:0] pin2;            // Second sampler stage
	reg        wr_d;            // Delayed write strobe
	reg        rd_d;            // Delayed read strobe
	// Task file
	reg [7:0]  feat;            // Feature select
	reg [7:0]  tlen;            // Transfer length
	reg [7:0]  snum;            // Start sector index
	reg [7:0]  amid;            // Address mid byte
	reg [7:0]  ahigh;           // Address high byte
	reg [7:0]  dh;              // Drive/head select
	reg [7:0]  errr;            // Error register
	reg [7:0]  stat;            // Status as read
	// Command state
	reg [2:0]  st;              // Sequencer state
	reg [3:0]  tmr;             // Busy hold timer
	reg        busy;            // Busy flag
	reg        drq;             // Data request
	reg        err;             // Error flag
	reg        wf;              // Write fault
	reg [7:0]  blk;             // Block size, 0 = multiple off
	reg        multi;           // Multiple mode command
	reg        lng;             // Long write
	reg [1:0]  op;              // Media operation
	reg [27:0] slba;            // Start address
	reg [8:0]  total;           // Sectors requested
	reg [8:0]  sent;            // Sectors received
	reg [8:0]  okc;             // Sectors written well
	reg [8:0]  inblk;           // Sectors left in block
	reg [8:0]  wcnt;            // Word index within sector
	reg [8:0]  pend;            // Commits awaiting answer
	reg        fail;            // A sector failed
	reg        fpush;           // FIFO push strobe
	reg [15:0] fdata;           // FIFO push word
	wire       f_rdy;           // FIFO has room
	wire       wr_e;            // Host write taken
	wire       rd_s;            // Host read starts
	wire       rd_x;            // Host read ends
	wire [2:0] ra;              // Register offset
	wire [15:0] hd;             // Host data
	wire [8:0] bs;              // Effective block size
	wire       last_w;          // Last word of sector
	wire       ok_done;         // Good answer this cycle
	wire       bad_done;        // First failure this cycle
	wire [8:0] next_pend;       // Outstanding after edge
	wire [27:0] ok_lba;         // Address of failing sector
	wire       int_set;         // Interrupt event

	assign ra = pin2[20:18];
	assign hd = pin2[15:0];
	assign wr_e = ~pin2[21] & pin2[17] & ~wr_d;
	assign rd_s = ~pin2[21] & ~pin2[16] & rd_d;
	assign rd_x = pin2[16] & ~rd_d;
	assign bs = multi ? {1'b0, blk} : 9'h001;
	assign last_w = (wcnt == (lng ? `AWCE_LONG_LAST : `AWCE_SEC_LAST));
	assign ok_done = media_done_i & ~media_fail_i & ~fail;
	assign bad_done = media_done_i & media_fail_i & ~fail;
	assign next_pend = pend + {8'h00, media_commit_o} - {8'h00, media_done_i};
	assign ok_lba = slba + {19'h0, okc};

	// Sectors in the next block: full block or the remainder
	function [8:0] blen;
		input [8:0] left;
		input [8:0] size;
		begin
			blen = (left < size) ? left : size;
		end
	endfunction

	// Size supported when a power of two within range
	function okblk;
		input [7:0] v;
		begin
			okblk = ((v & (v - 8'h01)) == 8'h00) && ({1'b0, v} <= MAXB);
		end
	endfunction

	awce_fifo #(
		.W  (16),
		.D  (FDEPTH),
		.AW (3)
	) u_fifo (
		.clock_i     (clock_i),
		.rst_i       (rst_i),
		.in_valid_i  (fpush),
		.in_data_i   (fdata),
		.in_ready_o  (f_rdy),
		.out_valid_o (media_valid_o),
		.out_data_o  (media_data_o),
		.out_ready_i (media_ready_i)
	);

	// Two-stage sampling of every IDE pin
	always @(posedge clock_i) begin
		if (rst_i) begin
			pin1 <= `AWCE_PIN_IDLE;
			pin2 <= `AWCE_PIN_IDLE;
			wr_d <= 1'b1;
			rd_d <= 1'b1;
		end else begin
			pin1 <= {ide_cs_n_i, ide_addr_i, ide_wr_n_i, ide_rd_n_i, ide_d_i};
			pin2 <= pin1;
			wr_d <= pin2[17];
			rd_d <= pin2[16];
		end
	end

	// Read port: drive on strobe, release after it
	always @(posedge clock_i) begin
		if (rst_i) begin
			ide_d_o <= 16'h0000;
			ide_d_oe_n_o <= 1'b1;
		end else if (rd_s) begin
			ide_d_oe_n_o <= 1'b0;
			if (ra == `AWCE_OFS_FEAT)
				ide_d_o <= {8'h00, errr};
			else if (ra == `AWCE_OFS_LEN)
				ide_d_o <= {8'h00, tlen};
			else if (ra == `AWCE_OFS_SNUM)
				ide_d_o <= {8'h00, snum};
			else if (ra == `AWCE_OFS_MID)
				ide_d_o <= {8'h00, amid};
			else if (ra == `AWCE_OFS_HIGH)
				ide_d_o <= {8'h00, ahigh};
			else if (ra == `AWCE_OFS_DH)
				ide_d_o <= {8'h00, dh};
			else if (ra == `AWCE_OFS_CMD)
				ide_d_o <= {8'h00, stat};
			else
				ide_d_o <= 16'h0000; // Data port is write-only here
		end else if (rd_x) begin
			ide_d_oe_n_o <= 1'b1;
		end
	end

	// Interrupt: set wins over the clear of a status read
	always @(posedge clock_i) begin
		if (rst_i)
			ide_intrq_o <= 1'b0;
		else if (int_set)
			ide_intrq_o <= 1'b1;
		else if (rd_s && ra == `AWCE_OFS_CMD)
			ide_intrq_o <= 1'b0;
	end

	// Status image; a full FIFO shows as busy to stall the host
	always @(posedge clock_i) begin
		if (rst_i)
			stat <= `AWCE_RST_STAT;
		else begin
			stat <= 8'h00;
			stat[`AWCE_ST_BUSY] <= busy | (drq & ~f_rdy);
			stat[`AWCE_ST_RDY] <= 1'b1;
			stat[`AWCE_ST_WF] <= wf;
			stat[`AWCE_ST_SEEK] <= 1'b1;
			stat[`AWCE_ST_DRQ] <= drq & f_rdy;
			stat[`AWCE_ST_ERR] <= err;
		end
	end

	// Interrupt events from the sequencer
	reg ev;                     // Interrupt request this cycle
	assign int_set = ev;

	// Command sequencer and task file
	always @(posedge clock_i) begin
		if (rst_i) begin
			feat <= `AWCE_RST_ZERO;
			tlen <= `AWCE_RST_LEN;
			snum <= `AWCE_RST_SNUM;
			amid <= `AWCE_RST_ZERO;
			ahigh <= `AWCE_RST_ZERO;
			dh <= `AWCE_RST_DH;
			errr <= `AWCE_RST_ZERO;
			st <= ST_IDLE;
			tmr <= 4'h0;
			busy <= 1'b0;
			drq <= 1'b0;
			err <= 1'b0;
			wf <= 1'b0;
			blk <= 8'h00;
			multi <= 1'b0;
			lng <= 1'b0;
			op <= `AWCE_OP_WR;
			slba <= 28'h0;
			total <= 9'h0;
			sent <= 9'h0;
			okc <= 9'h0;
			inblk <= 9'h0;
			wcnt <= 9'h0;
			pend <= 9'h0;
			fail <= 1'b0;
			fpush <= 1'b0;
			fdata <= 16'h0000;
			ev <= 1'b0;
			media_commit_o <= 1'b0;
			media_lba_o <= 28'h0;
			media_op_o <= `AWCE_OP_WR;
		end else begin
			ev <= 1'b0;
			fpush <= 1'b0;
			media_commit_o <= 1'b0;
			pend <= next_pend;
			// Media answers arrive in order
			if (ok_done)
				okc <= okc + 9'h001;
			if (bad_done)
				fail <= 1'b1;
			// Task-file writes only while idle
			if (wr_e && st == ST_IDLE && !busy) begin
				if (ra == `AWCE_OFS_FEAT)
					feat <= hd[7:0];
				else if (ra == `AWCE_OFS_LEN)
					tlen <= hd[7:0];
				else if (ra == `AWCE_OFS_SNUM)
					snum <= hd[7:0];
				else if (ra == `AWCE_OFS_MID)
					amid <= hd[7:0];
				else if (ra == `AWCE_OFS_HIGH)
					ahigh <= hd[7:0];
				else if (ra == `AWCE_OFS_DH)
					dh <= hd[7:0];
			end
			case (st)
			ST_IDLE: begin
				if (wr_e && ra == `AWCE_OFS_CMD) begin
					err <= 1'b0;
					wf <= 1'b0;
					errr <= 8'h00;
					fail <= 1'b0;
					okc <= 9'h0;
					sent <= 9'h0;
					wcnt <= 9'h0;
					multi <= 1'b0;
					lng <= 1'b0;
					tmr <= 4'h0;
					// Linear address from the task file
					slba <= {dh[3:0], ahigh, amid, snum};
					total <= (tlen == 8'h00) ? `AWCE_FULL_SECS : {1'b0, tlen};
					busy <= 1'b1;
					st <= ST_SETUP;
					case (hd[7:0])
					`AWCE_CMD_WRS0, `AWCE_CMD_WRS1: op <= `AWCE_OP_WR;
					`AWCE_CMD_WRNE: op <= `AWCE_OP_WRNE;
					`AWCE_CMD_WVER: op <= `AWCE_OP_WVER;
					`AWCE_CMD_WLONG0, `AWCE_CMD_WLONG1: begin
						op <= `AWCE_OP_WR;
						lng <= 1'b1;
						total <= 9'h001;
					end
					`AWCE_CMD_WBUF: begin
						op <= `AWCE_OP_BUF;
						total <= 9'h001;
						slba <= 28'h0;
					end
					`AWCE_CMD_WMUL, `AWCE_CMD_WMULNE: begin
						multi <= 1'b1;
						op <= (hd[7:0] == `AWCE_CMD_WMUL) ? `AWCE_OP_WR :
							`AWCE_OP_WRNE;
						if (blk == 8'h00) begin
							// No block size set, or multiple disabled
							busy <= 1'b0;
							err <= 1'b1;
							errr <= `AWCE_ER_ABRT;
							ev <= 1'b1;
							st <= ST_IDLE;
						end
					end
					`AWCE_CMD_SETMUL: begin
						busy <= 1'b0;
						ev <= 1'b1;
						st <= ST_IDLE;
						if (tlen == 8'h00)
							blk <= 8'h00;
						else if (okblk(tlen))
							blk <= tlen;
						else begin
							blk <= 8'h00;
							err <= 1'b1;
							errr <= `AWCE_ER_ABRT;
						end
					end
					default: begin
						// Unknown or unhandled code
						busy <= 1'b0;
						err <= 1'b1;
						errr <= `AWCE_ER_ABRT;
						ev <= 1'b1;
						st <= ST_IDLE;
					end
					endcase
				end
			end
			ST_SETUP: begin
				// Busy held long enough to be seen, then DRQ
				tmr <= tmr + 4'h1;
				if (tmr == BUSY_CYC - 4'h1) begin
					busy <= 1'b0;
					drq <= 1'b1;
					inblk <= blen(total, bs);
					st <= ST_XFER; // No interrupt on first fill
				end
			end
			ST_XFER: begin
				if (wr_e && ra == `AWCE_OFS_DATA) begin
					wcnt <= last_w ? 9'h0 : wcnt + 9'h001;
					// Long-write trailer words never reach media
					if (wcnt <= `AWCE_SEC_LAST) begin
						fpush <= 1'b1;
						fdata <= hd;
					end
					if (last_w) begin
						media_commit_o <= 1'b1;
						media_lba_o <= slba + {19'h0, sent};
						media_op_o <= op;
						sent <= sent + 9'h001;
						inblk <= inblk - 9'h001;
						if (inblk == 9'h001) begin
							// Block received: busy until media answers
							drq <= 1'b0;
							busy <= 1'b1;
							st <= ST_DRAIN;
						end
					end
				end
			end
			ST_DRAIN: begin
				if (next_pend == 9'h0 && !media_commit_o) begin
					if (fail || bad_done) begin
						// Stop at failing sector; residual count
						{dh[3:0], ahigh, amid, snum} <= ok_lba;
						tlen <= total[7:0] - okc[7:0];
						err <= 1'b1;
						wf <= 1'b1;
						errr <= `AWCE_ER_ABRT;
						busy <= 1'b0;
						ev <= 1'b1;
						st <= ST_IDLE;
					end else if (sent == total) begin
						if (op != `AWCE_OP_BUF) begin
							{dh[3:0], ahigh, amid, snum} <= slba + {19'h0, total} - 28'h1;
							tlen <= 8'h00;
						end
						busy <= 1'b0;
						ev <= 1'b1;
						st <= ST_IDLE;
					end else begin
						// Next block or sector: DRQ with interrupt
						busy <= 1'b0;
						drq <= 1'b1;
						ev <= 1'b1;
						inblk <= blen(total - sent, bs);
						st <= ST_XFER;
					end
				end
			end
			default: st <= ST_IDLE;
			endcase
		end
	end
endmodule

// ---- verif/awce_engine_assertions.sv ----
// Port checker for the write command engine.
// Assumes host strobes change off the rising clock edge.
`timescale 1ns/10ps
module awce_engine_checker #(
	parameter FDEPTH = 8
) (
	input wire        clock_i,
	input wire        rst_i,
	input wire        ide_cs_n_i,
	input wire [2:0]  ide_addr_i,
	input wire        ide_rd_n_i,
	input wire [15:0] ide_d_o,
	input wire        ide_d_oe_n_o,
	input wire        ide_intrq_o,
	input wire        media_valid_o,
	input wire [15:0] media_data_o,
	input wire        media_ready_i,
	input wire        media_commit_o
);
	int pops;    // Words taken by the media
	int commits; // Sector commits seen
	// Counters; a staging slack of two FIFO depths keeps them safe
	always @(posedge clock_i) begin
		if (rst_i) begin
			pops    <= 0;
			commits <= 0;
		end else begin
			pops    <= pops + ((media_valid_o && media_ready_i) ? 1 : 0);
			commits <= commits + (media_commit_o ? 1 : 0);
		end
	end
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);
	sequence s_stat_rd;
		$fell(ide_rd_n_i) && !ide_cs_n_i && ide_addr_i == 3'h7 && ide_intrq_o;
	endsequence
	sequence s_word_wait;
		media_valid_o && !media_ready_i;
	endsequence
	property p_reset_idle;
		$fell(rst_i) |-> ide_d_oe_n_o && !ide_intrq_o && !media_commit_o && !media_valid_o;
	endproperty
	property p_commit_pulse;
		media_commit_o |=> !media_commit_o;
	endproperty
	property p_media_hold;
		s_word_wait |=> media_valid_o && $stable(media_data_o);
	endproperty
	property p_pop_max;
		pops <= 256 * (commits + 1);
	endproperty
	property p_pop_min;
		pops + 2 * FDEPTH >= 256 * commits;
	endproperty
	property p_oe_cause;
		$fell(ide_d_oe_n_o) |-> !$past(ide_rd_n_i, 3) && !$past(ide_cs_n_i, 3);
	endproperty
	property p_oe_release;
		$rose(ide_rd_n_i) |-> ##[1:6] ide_d_oe_n_o;
	endproperty
	property p_high_zero;
		!ide_d_oe_n_o |-> ide_d_o[15:8] == 8'h00;
	endproperty
	property p_irq_clear;
		s_stat_rd |-> ##[1:8] !ide_intrq_o;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("outputs busy after reset");
	a_commit_pulse: assert property (p_commit_pulse) else $error("commit too long");
	a_media_hold: assert property (p_media_hold) else $error("media word dropped");
	a_pop_max: assert property (p_pop_max) else $error("too many words");
	a_pop_min: assert property (p_pop_min) else $error("too few words");
	a_oe_cause: assert property (p_oe_cause) else $error("bus driven unasked");
	a_oe_release: assert property (p_oe_release) else $error("bus not released");
	a_high_zero: assert property (p_high_zero) else $error("high byte set");
	a_irq_clear: assert property (p_irq_clear) else $error("irq not cleared");
endmodule
bind awce_engine awce_engine_checker #(.FDEPTH(FDEPTH)) awce_engine_checker_inst (
	.clock_i(clock_i), .rst_i(rst_i), .ide_cs_n_i(ide_cs_n_i), .ide_addr_i(ide_addr_i),
	.ide_rd_n_i(ide_rd_n_i), .ide_d_o(ide_d_o), .ide_d_oe_n_o(ide_d_oe_n_o),
	.ide_intrq_o(ide_intrq_o), .media_valid_o(media_valid_o), .media_data_o(media_data_o),
	.media_ready_i(media_ready_i), .media_commit_o(media_commit_o));

// ---- verif/awce_media_model.sv ----
// Flash media model: takes words, answers commits in order.
// Assumes one commit per 256 queued words.
`timescale 1ns/10ps
module awce_media_model (
	input  wire        clock_i,
	input  wire        rst_i,
	input  wire        media_valid_i,
	input  wire [15:0] media_data_i,
	input  wire        media_commit_i,
	input  wire [27:0] media_lba_i,
	input  wire [1:0]  media_op_i,
	input  wire        hold_i,
	input  wire        slow_i,
	input  wire [7:0]  fail_at_i,
	output wire        media_ready_o,
	output reg         media_done_o,
	output reg         media_fail_o,
	output reg  [31:0] words_o,
	output reg  [31:0] bad_o,
	output reg  [7:0]  answered_o,
	output reg  [27:0] last_lba_o,
	output reg  [1:0]  last_op_o
);
	reg  [3:0] ph;   // Phase for periodic stalls
	reg  [7:0] pend; // Commits not yet answered
	reg  [7:0] tmr;  // Program time left
	wire       ans;  // Answer now; never before the sector's words arrived
	assign ans = pend != 8'h00 && tmr == 8'h00 && words_o >= 256 * (answered_o + 1);
	assign media_ready_o = !hold_i && !ph[2];
	// Stalls half of the time; answers promptly or slowly
	always @(posedge clock_i) begin
		if (rst_i) begin
			ph           <= 4'h0;
			pend         <= 8'h00;
			tmr          <= 8'h00;
			words_o      <= 32'h0;
			bad_o        <= 32'h0;
			answered_o   <= 8'h00;
			media_done_o <= 1'b0;
			media_fail_o <= 1'b0;
		end else begin
			ph           <= ph + 4'h1;
			media_done_o <= ans;
			media_fail_o <= ans && answered_o == fail_at_i;
			pend         <= pend + {7'h00, media_commit_i} - {7'h00, ans};
			if (media_valid_i && media_ready_o) begin
				words_o <= words_o + 32'h1;
				// Word n of every sector carries n with 5a above it
				if (media_data_i != {8'h5a, words_o[7:0]})
					bad_o <= bad_o + 32'h1;
			end
			if (media_commit_i) begin
				last_lba_o <= media_lba_i;
				last_op_o  <= media_op_i;
			end
			if (ans) begin
				answered_o <= answered_o + 8'h01;
				tmr        <= slow_i ? 8'h28 : 8'h02;
			end else if (tmr != 8'h00) begin
				tmr <= tmr - 8'h01;
			end
		end
	end
endmodule

// ---- verif/test_ata_write_command_engine.sv ----
// Bench for the write command engine: host register cycles on the pins.
// Assumes the media model as far side of the data path.
`timescale 1ns/10ps
module test_ata_write_command_engine;
	reg         clock_i, rst_i, ide_cs_n, ide_wr_n, ide_rd_n, fill, slow;
	reg  [2:0]  ide_addr;
	reg  [15:0] ide_d;
	reg  [7:0]  fail_at;
	wire [15:0] ide_d_o, media_data;
	wire        oe_n, irq, m_valid, m_ready, commit, done, m_fail;
	wire [27:0] m_lba, last_lba;
	wire [1:0]  m_op, last_op;
	wire [31:0] words, bad;
	wire [7:0]  answered;
	int         n_errors, n_tests, i, k, w0;
	awce_engine awce_engine_inst (.clock_i(clock_i), .rst_i(rst_i), .ide_cs_n_i(ide_cs_n),
		.ide_addr_i(ide_addr), .ide_wr_n_i(ide_wr_n), .ide_rd_n_i(ide_rd_n), .ide_d_i(ide_d),
		.ide_d_o(ide_d_o), .ide_d_oe_n_o(oe_n), .ide_intrq_o(irq), .media_valid_o(m_valid),
		.media_data_o(media_data), .media_ready_i(m_ready), .media_commit_o(commit),
		.media_lba_o(m_lba), .media_op_o(m_op), .media_done_i(done), .media_fail_i(m_fail));
	awce_media_model awce_media_model_inst (.clock_i(clock_i), .rst_i(rst_i),
		.media_valid_i(m_valid), .media_data_i(media_data), .media_commit_i(commit),
		.media_lba_i(m_lba), .bad_o(bad),
		.media_op_i(m_op), .hold_i(fill), .slow_i(slow), .fail_at_i(fail_at),
		.media_ready_o(m_ready), .media_done_o(done), .media_fail_o(m_fail),
		.words_o(words), .answered_o(answered), .last_lba_o(last_lba), .last_op_o(last_op));
	// 10 MHz clock
	initial begin
		clock_i = 1'b0;
		forever #50 clock_i = ~clock_i;
	end
	task automatic complete_run;
		if (n_errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clock_i);
	endtask
	task automatic chk(input [31:0] got, input [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
			n_errors++;
		end
	endtask
	task automatic give_up;
		$display("unexpected at %0t: wait ran out", $time);
		n_errors++;
		complete_run();
	endtask
	// Strobes held four cycles; data bus inverted once released
	task automatic wr(input [2:0] a, input [15:0] d);
		ide_addr = a;
		ide_d = d;
		ide_cs_n = 1'b0;
		ide_wr_n = 1'b0;
		cyc(4);
		ide_wr_n = 1'b1;
		cyc(1);
		ide_cs_n = 1'b1;
		ide_d = ~d;
		cyc(3);
	endtask
	task automatic rd(input [2:0] a, output [15:0] q);
		ide_addr = a;
		ide_cs_n = 1'b0;
		ide_rd_n = 1'b0;
		cyc(6);
		q = ide_d_o;
		ide_rd_n = 1'b1;
		cyc(1);
		ide_cs_n = 1'b1;
		cyc(5);
	endtask
	task automatic rchk(input [2:0] a, input [15:0] exp);
		reg [15:0] q;
		rd(a, q);
		chk(q, exp);
	endtask
	task automatic wait_irq;
		int n;
		for (n = 0; n < 4000 && irq !== 1'b1; n++)
			cyc(1);
		if (irq !== 1'b1)
			give_up();
	endtask
	task automatic poll_drq;
		reg [15:0] q;
		int n;
		for (n = 0; n < 100; n++) begin
			rd(3'h7, q);
			if (q[3] === 1'b1)
				return;
		end
		give_up();
	endtask
	task automatic setaddr;
		wr(3'h3, 16'h0044);
		wr(3'h4, 16'h0033);
		wr(3'h5, 16'h0022);
		wr(3'h6, 16'h00e1);
	endtask
	// One command: blocks of blk sectors, words per sector
	task automatic run_cmd(input [7:0] code, input [7:0] len, input int send,
		input int words_n, input int blk);
		int s;
		int n;
		reg [15:0] q;
		// Clear an interrupt left over from the previous command
		rd(3'h7, q);
		wr(3'h2, {8'h00, len});
		wr(3'h7, {8'h00, code});
		for (s = 0; s < send; s++) begin
			if (s == 0) begin
				// Busy shows at once; DRQ then comes without an interrupt
				rd(3'h7, q);
				chk(q[7], 1);
				chk(irq, 0);
				poll_drq();
				chk(irq, 0);
			end else if (s % blk == 0) begin
				wait_irq();
				rchk(3'h7, 16'h0058);
			end else
				chk(irq, 0);
			for (n = 0; n < words_n; n++) begin
				if (fill && n == 8) begin
					rd(3'h7, q);
					chk(q[7], 1);
					fill = 1'b0;
				end
				wr(3'h0, n[15:0] ^ 16'h5a00);
			end
		end
		wait_irq();
	endtask
	initial begin
		{ide_cs_n, ide_wr_n, ide_rd_n} = 3'h7;
		{ide_addr, ide_d, fill, slow} = 21'h0;
		fail_at = 8'hff;
		n_errors = 0;
		n_tests = 0;
		rst_i = 1'b1;
		cyc(4);
		rst_i = 1'b0;
		for (i = 0; i < 8; i++)
			rchk(i[2:0], {8'h00, 64'h50a0000001010000 >> (i * 8)} & 16'h00ff);
		// Sector, no-erase, verify and long writes
		for (k = 0; k < 6; k++) begin
			setaddr();
			w0 = words;
			run_cmd(48'h33323c383130 >> (k * 8), k == 0 ? 2 : 1, k == 0 ? 2 : 1,
				k > 3 ? 258 : 256, 1);
			chk(words - w0, k == 0 ? 512 : 256);
			chk(last_lba, k == 0 ? 28'h1223345 : 28'h1223344);
			chk(last_op, k == 2 ? 1 : (k == 3 ? 2 : 0));
			rchk(3'h7, 16'h0050);
			rchk(3'h3, k == 0 ? 16'h0045 : 16'h0044);
		end
		// Buffer write with the media stalled until the FIFO is full
		setaddr();
		fill = 1'b1;
		w0 = words;
		run_cmd(8'he8, 8'h07, 1, 256, 1);
		chk(words - w0, 256);
		chk(last_op, 3);
		rchk(3'h2, 16'h0007);
		rchk(3'h3, 16'h0044);
		rchk(3'h7, 16'h0050);
		// Multiple write, slow media, blocks of four
		setaddr();
		slow = 1'b1;
		run_cmd(8'hc6, 8'h04, 0, 256, 1);
		run_cmd(8'hc5, 8'h06, 6, 256, 4);
		rchk(3'h7, 16'h0050);
		rchk(3'h3, 16'h0049);
		chk(last_op, 0);
		slow = 1'b0;
		// Failure on the third sector
		setaddr();
		fail_at = answered + 8'h02;
		run_cmd(8'hcd, 8'h08, 4, 256, 4);
		rchk(3'h7, 16'h0071);
		rchk(3'h1, 16'h0004);
		rchk(3'h3, 16'h0046);
		rchk(3'h2, 16'h0006);
		chk(last_op, 1);
		fail_at = 8'hff;
		// Unsupported block size, multiple disabled, then unknown code
		run_cmd(8'hc6, 8'h03, 0, 256, 1);
		rchk(3'h7, 16'h0051);
		run_cmd(8'hc6, 8'h00, 0, 256, 1);
		run_cmd(8'hc5, 8'h02, 0, 256, 1);
		rchk(3'h7, 16'h0051);
		rchk(3'h1, 16'h0004);
		run_cmd(8'h55, 8'h01, 0, 256, 1);
		rchk(3'h7, 16'h0051);
		chk(bad, 0);
		complete_run();
	end
endmodule
